// ### src/occ_consts.svh
// Register map, field positions and reset values of the output channel control.
// Included by every design file that decodes registers or fields.
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define OCC_REG_WIDTH 8
`define OCC_DIV_WIDTH 8

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OCC_ADDR_DIV5 8'h28
`define OCC_ADDR_CTL6 8'h29
`define OCC_ADDR_STAT 8'h2a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OCC_DIV5_RST 8'h02
`define OCC_CTL6_RST 8'h18
`define OCC_READ_IDLE 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCC_SRC_HI 7
`define OCC_SRC_LO 6
`define OCC_FMT_HI 5
`define OCC_FMT_LO 4
`define OCC_MODE1_HI 3
`define OCC_MODE1_LO 2
`define OCC_MODE2_HI 1
`define OCC_MODE2_LO 0
`define OCC_STAT_BYPASS 0
`define OCC_STAT_P_OE 1
`define OCC_STAT_N_OE 2
`define OCC_STAT_CH5 3

`endif

// ### src/occ_pkg.sv
// Types shared by the output channel control.
// Assumes field codes run 0 to 3 in the declared order.
package occ_pkg;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  typedef enum logic [1:0] {OCC_SRC_PLL1, OCC_SRC_PLL2, OCC_SRC_PRI, OCC_SRC_SEC} occ_src_t;
  typedef enum logic [1:0] {OCC_FMT_OFF, OCC_FMT_ACDIFF, OCC_FMT_HCSL, OCC_FMT_CMOS} occ_fmt_t;
  typedef enum logic [1:0] {OCC_LEG_TRI, OCC_LEG_LOW, OCC_LEG_INV, OCC_LEG_TRUE} occ_leg_t;

  // Reference sources skip the divider
  function automatic logic occ_is_ref(input occ_src_t src);
    return (src == OCC_SRC_PRI) || (src == OCC_SRC_SEC);
  endfunction

endpackage

// ### src/occ_divider.sv
// Edge-counting output divider for one channel.
// Assumes the source clock arrives as a level well below half the clock rate.
`timescale 1ns/1ps
`include "occ_consts.svh"
module occ_divider import occ_pkg::*; #(
  parameter int WIDTH = `OCC_DIV_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic src_level,
  input wire logic [WIDTH-1:0] ratio_code,
  output logic div_out
);
  logic src_q;
  logic next_src_q;
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_div_out;
  logic rise;
  logic [WIDTH:0] half;

  generate
    if (WIDTH < 1 || WIDTH > `OCC_REG_WIDTH) begin : g_bad_width
      $error("occ_divider: WIDTH out of range");
    end
  endgenerate

  // ----------------------------------------
  // Count source edges, code plus one per period
  // ----------------------------------------
  always_comb begin
    rise = src_level & ~src_q;
    half = ({1'h0, ratio_code} + (WIDTH + 1)'(2)) >> 1;
    next_src_q = src_level;
    next_cnt = cnt;
    if (rise) begin
      // Restart also catches a code lowered mid-period
      if (cnt >= ratio_code) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + WIDTH'(1);
      end
    end
    if (ratio_code == '0) begin
      next_div_out = src_level;
    end else begin
      next_div_out = ({1'h0, next_cnt} < half);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= 1'h0;
      cnt <= '0;
      div_out <= 1'h0;
    end else begin
      src_q <= next_src_q;
      cnt <= next_cnt;
      div_out <= next_div_out;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div_wrap_a:
    assert property (@(posedge clock) disable iff (!rst_n)
      (rise && cnt == ratio_code) |=> (cnt == '0))
    else $error("divider did not wrap at its code");
  div_unity_a:
    assert property (@(posedge clock) disable iff (!rst_n)
      (ratio_code == '0) |=> (div_out == $past(src_level)))
    else $error("code zero did not pass the source");
  div_wrap_c:
    cover property (@(posedge clock) disable iff (!rst_n)
      rise && ratio_code > '0 && cnt == ratio_code);

endmodule // occ_divider

// ### src/occ_top.sv
// Output channel control: channel 5 divider, channel 6 source and driver.
// Assumes synchronous inputs and one-cycle register strobes, never both at once.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "occ_consts.svh"
module occ_top import occ_pkg::*; #(
  parameter int DIV_WIDTH = `OCC_DIV_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic nv_load,
  input wire logic [7:0] nv_div5,
  input wire logic [7:0] nv_ctl6,
  input wire logic ch5_src,
  input wire logic ch6_pll1,
  input wire logic ch6_pll2,
  input wire logic pri_ref,
  input wire logic pri_ref_doubled,
  input wire logic sec_ref,
  input wire logic sec_ref_doubled,
  input wire logic doubler_en,
  input wire logic [DIV_WIDTH-1:0] ch6_divider_code,
  output logic ch5_out,
  output logic ch6_out_p,
  output logic ch6_out_p_oe,
  output logic ch6_out_n,
  output logic ch6_out_n_oe
);
  logic [7:0] channel5_divider;
  logic [7:0] next_channel5_divider;
  logic [7:0] channel6_output_control;
  logic [7:0] next_channel6_output_control;
  logic [7:0] next_rd_data;
  logic [7:0] status;
  logic ch6_clk_q;
  logic next_ch6_clk_q;
  logic pll_clk;
  logic div6_out;
  logic ch6_bypass;
  occ_src_t ch6_source_select;
  occ_fmt_t ch6_format;
  occ_leg_t ch6_positive_leg_mode;
  occ_leg_t ch6_negative_leg_mode;
  logic [1:0] leg_val;
  logic [1:0] leg_oe;

  generate
    if (DIV_WIDTH < 1 || DIV_WIDTH > `OCC_REG_WIDTH) begin : g_bad_width
      $error("occ_top: DIV_WIDTH out of range");
    end
  endgenerate

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign ch6_source_select =
    occ_src_t'(channel6_output_control[`OCC_SRC_HI:`OCC_SRC_LO]);
  assign ch6_format = occ_fmt_t'(channel6_output_control[`OCC_FMT_HI:`OCC_FMT_LO]);
  assign ch6_positive_leg_mode =
    occ_leg_t'(channel6_output_control[`OCC_MODE1_HI:`OCC_MODE1_LO]);
  assign ch6_negative_leg_mode =
    occ_leg_t'(channel6_output_control[`OCC_MODE2_HI:`OCC_MODE2_LO]);
  assign ch6_bypass = occ_is_ref(ch6_source_select);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_comb begin
    next_channel5_divider = channel5_divider;
    next_channel6_output_control = channel6_output_control;
    // Stored configuration first, so a same-cycle bus write still lands
    if (nv_load) begin
      next_channel5_divider = nv_div5;
      next_channel6_output_control = nv_ctl6;
    end
    if (wr_en && addr == `OCC_ADDR_DIV5) begin
      next_channel5_divider = wr_data;
    end
    if (wr_en && addr == `OCC_ADDR_CTL6) begin
      next_channel6_output_control = wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel5_divider <= `OCC_DIV5_RST;
      channel6_output_control <= `OCC_CTL6_RST;
    end else begin
      channel5_divider <= next_channel5_divider;
      channel6_output_control <= next_channel6_output_control;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    status = `OCC_READ_IDLE;
    status[`OCC_STAT_BYPASS] = ch6_bypass;
    status[`OCC_STAT_P_OE] = ch6_out_p_oe;
    status[`OCC_STAT_N_OE] = ch6_out_n_oe;
    status[`OCC_STAT_CH5] = ch5_out;
    next_rd_data = `OCC_READ_IDLE;
    if (rd_en) begin
      case (addr)
        `OCC_ADDR_DIV5: begin
          next_rd_data = channel5_divider;
        end
        `OCC_ADDR_CTL6: begin
          next_rd_data = channel6_output_control;
        end
        `OCC_ADDR_STAT: begin
          next_rd_data = status;
        end
        default: begin
          next_rd_data = `OCC_READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `OCC_READ_IDLE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  occ_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_div5 (
    .clock(clock),
    .rst_n(rst_n),
    .src_level(ch5_src),
    .ratio_code(channel5_divider[DIV_WIDTH-1:0]),
    .div_out(ch5_out)
  );

  assign pll_clk = (ch6_source_select == OCC_SRC_PLL2) ? ch6_pll2 : ch6_pll1;

  occ_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_div6 (
    .clock(clock),
    .rst_n(rst_n),
    .src_level(pll_clk),
    .ratio_code(ch6_divider_code),
    .div_out(div6_out)
  );

  // ----------------------------------------
  // Channel 6 source
  // ----------------------------------------
  always_comb begin
    case (ch6_source_select)
      OCC_SRC_PRI: begin
        next_ch6_clk_q = doubler_en ? pri_ref_doubled : pri_ref;
      end
      OCC_SRC_SEC: begin
        next_ch6_clk_q = doubler_en ? sec_ref_doubled : sec_ref;
      end
      default: begin
        next_ch6_clk_q = div6_out;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch6_clk_q <= 1'h0;
    end else begin
      ch6_clk_q <= next_ch6_clk_q;
    end
  end

  // ----------------------------------------
  // Channel 6 driver legs
  // ----------------------------------------
  // Differential modes only trim analog levels, so logic sees true/complement
  function automatic logic [1:0] leg_drive(input occ_fmt_t fmt, input occ_leg_t mode,
                                           input logic clk, input logic neg);
    logic [1:0] drv;
    drv = 2'h0;
    case (fmt)
      OCC_FMT_OFF: begin
        drv = 2'h0;
      end
      OCC_FMT_CMOS: begin
        case (mode)
          OCC_LEG_LOW: begin
            drv = 2'h2;
          end
          OCC_LEG_INV: begin
            drv = {1'h1, ~clk};
          end
          OCC_LEG_TRUE: begin
            drv = {1'h1, clk};
          end
          default: begin
            drv = 2'h0;
          end
        endcase
      end
      default: begin
        drv = {1'h1, clk ^ neg};
      end
    endcase
    return drv;
  endfunction

  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_leg
      logic [1:0] next_drv;
      always_comb begin
        next_drv = leg_drive(ch6_format,
                             (gi == 0) ? ch6_positive_leg_mode : ch6_negative_leg_mode,
                             ch6_clk_q, (gi == 1));
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          leg_oe[gi] <= 1'h0;
          leg_val[gi] <= 1'h0;
        end else begin
          leg_oe[gi] <= next_drv[1];
          leg_val[gi] <= next_drv[0];
        end
      end
    end
  endgenerate

  assign ch6_out_p_oe = leg_oe[0];
  assign ch6_out_p = leg_val[0];
  assign ch6_out_n_oe = leg_oe[1];
  assign ch6_out_n = leg_val[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic div5_touched;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div5_touched <= 1'h0;
    end else if (nv_load || (wr_en && addr == `OCC_ADDR_DIV5)) begin
      div5_touched <= 1'h1;
    end
  end

  div5_reset_a:
    assert property (!div5_touched |-> channel5_divider == `OCC_DIV5_RST)
    else $error("divider code left its reset value unwritten");
  div5_write_a:
    assert property (wr_en && addr == `OCC_ADDR_DIV5 |=> channel5_divider == $past(wr_data))
    else $error("divider write lost");
  ctl6_read_a:
    assert property (rd_en && addr == `OCC_ADDR_CTL6 ##1 !rd_en
      |-> rd_data == $past(channel6_output_control) ##1 rd_data == `OCC_READ_IDLE)
    else $error("control readback wrong or held too long");
  pll_route_a:
    assert property (!ch6_bypass |=> ch6_clk_q == $past(div6_out))
    else $error("PLL source not taken through divider");
  ref_bypass_a:
    assert property (ch6_source_select == OCC_SRC_SEC && !doubler_en
      |=> ch6_clk_q == $past(sec_ref))
    else $error("reference not bypassing divider");
  doubler_sel_a:
    assert property (ch6_source_select == OCC_SRC_PRI && doubler_en
      |=> ch6_clk_q == $past(pri_ref_doubled))
    else $error("doubled reference not selected");
  fmt_off_a:
    assert property (ch6_format == OCC_FMT_OFF |=> !ch6_out_p_oe && !ch6_out_n_oe)
    else $error("disabled output still driven");
  leg_low_a:
    assert property (ch6_format == OCC_FMT_CMOS && ch6_positive_leg_mode == OCC_LEG_LOW
      |=> ch6_out_p_oe && !ch6_out_p)
    else $error("positive leg not driven low");
  leg_true_a:
    assert property (ch6_format == OCC_FMT_CMOS && ch6_negative_leg_mode == OCC_LEG_TRUE
      |=> ch6_out_n_oe && ch6_out_n == $past(ch6_clk_q))
    else $error("negative leg not true polarity");

  div5_write_c: cover property (wr_en && addr == `OCC_ADDR_DIV5);
  doubled_ref_c: cover property (ch6_bypass && doubler_en ##1 ch6_clk_q);
  cmos_inv_c: cover property (ch6_format == OCC_FMT_CMOS
    && ch6_positive_leg_mode == OCC_LEG_INV ##1 ch6_out_p_oe);

endmodule // occ_top

// ### testbench/occ_receiver.sv
// Downstream clock receiver model on the channel 6 output pins.
// Assumes legs and enables arrive registered on the device clock.
`timescale 1ns/1ps
module occ_receiver (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic leg_p,
  input wire logic leg_p_oe,
  input wire logic leg_n,
  input wire logic leg_n_oe,
  output logic pin_p,
  output logic pin_n
);
  logic float_q;

  // ----------------------------------------
  // Released pins
  // ----------------------------------------
  // No pull on these pins, so a released leg wanders rather than holding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      float_q <= 1'b0;
    end else begin
      float_q <= ~float_q;
    end
  end

  assign pin_p = leg_p_oe ? leg_p : float_q;
  assign pin_n = leg_n_oe ? leg_n : ~float_q;
endmodule // occ_receiver

// ### testbench/tb.sv
// Testbench of the output channel control: registers, divider, routing, legs.
// Assumes one-cycle strobes, read data in the cycle after the read strobe.
`timescale 1ns/1ps
`include "occ_consts.svh"
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic nv_load = 1'b0;
  logic [7:0] nv_div5 = 8'h00;
  logic [7:0] nv_ctl6 = 8'h00;
  logic [7:0] div6 = 8'h01;
  logic doubler_en = 1'b0;
  logic ch5_src = 1'b0;
  logic pll1 = 1'b0;
  logic pll2 = 1'b0;
  logic pri = 1'b0;
  logic pri_d = 1'b0;
  logic sec = 1'b0;
  logic sec_d = 1'b0;
  logic [7:0] rd_data;
  logic ch5_out;
  logic p;
  logic p_oe;
  logic n;
  logic n_oe;
  logic pin_p;
  logic pin_n;
  int cnt = 0;
  int num_errors = 0;
  int checked = 0;

  occ_top u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .nv_load(nv_load), .nv_div5(nv_div5), .nv_ctl6(nv_ctl6),
    .ch5_src(ch5_src), .ch6_pll1(pll1), .ch6_pll2(pll2), .pri_ref(pri), .pri_ref_doubled(pri_d),
    .sec_ref(sec), .sec_ref_doubled(sec_d), .doubler_en(doubler_en), .ch6_divider_code(div6),
    .ch5_out(ch5_out), .ch6_out_p(p), .ch6_out_p_oe(p_oe), .ch6_out_n(n), .ch6_out_n_oe(n_oe));
  occ_receiver u_rx (.clock(clock), .rst_n(rst_n), .leg_p(p), .leg_p_oe(p_oe), .leg_n(n),
    .leg_n_oe(n_oe), .pin_p(pin_p), .pin_n(pin_n));

  // ----------------------------------------
  // Clock and source waves
  // ----------------------------------------
  always #5 clock = ~clock;

  function automatic logic w(int c, int h);
    return ((c / h) % 2) != 0;
  endfunction

  // Periods distinct once pll1 and pll2 pass the channel 6 divider, so a rise count names the routed source
  always @(posedge clock) begin
    cnt <= cnt + 1;
    ch5_src <= w(cnt + 1, 2);
    pll1 <= w(cnt + 1, 2);
    pll2 <= w(cnt + 1, 3);
    pri <= w(cnt + 1, 2);
    pri_d <= w(cnt + 1, 3);
    sec <= w(cnt + 1, 5);
    sec_d <= w(cnt + 1, 7);
    if (cnt == 30000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task step;
    @(posedge clock);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(16'(rd_data & mask), 16'(exp));
  endtask

  // Source rises counted up to the next divided output rise
  task out_rise(output int srcs);
    int k;
    logic po;
    logic ps;
    srcs = 0;
    step();
    po = ch5_out;
    ps = ch5_src;
    for (k = 0; k < 1100; k++) begin
      step();
      if (ch5_src && !ps) srcs++;
      ps = ch5_src;
      if (ch5_out && !po) break;
      po = ch5_out;
    end
  endtask

  function automatic logic [1:0] leg(int f, int m, logic c, logic neg);
    case (f)
      0: return 2'b00;
      3: return (m == 0) ? 2'b00 : (m == 1) ? 2'b10 : {1'b1, c ^ (m == 2)};
      default: return {1'b1, c ^ neg};
    endcase
  endfunction

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int i;
    int j;
    int r;
    int e;
    logic c;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(`OCC_ADDR_DIV5, 8'hff, 8'h02);
    rd(`OCC_ADDR_CTL6, 8'hff, 8'h18);
    rd(8'h30, 8'hff, 8'h00);
    wr(`OCC_ADDR_DIV5, 8'ha5);
    wr(`OCC_ADDR_CTL6, 8'h3c);
    wr(`OCC_ADDR_STAT, 8'hff);
    wr(8'h30, 8'h55);
    rd(`OCC_ADDR_DIV5, 8'hff, 8'ha5);
    rd(`OCC_ADDR_CTL6, 8'hff, 8'h3c);
    @(posedge clock);
    nv_div5 <= 8'h07;
    nv_ctl6 <= 8'h9e;
    nv_load <= 1'b1;
    @(posedge clock);
    nv_load <= 1'b0;
    rd(`OCC_ADDR_DIV5, 8'hff, 8'h07);
    rd(`OCC_ADDR_CTL6, 8'hff, 8'h9e);
    // Boundary codes of the channel 5 divider
    for (i = 0; i < 4; i++) begin
      e = (i == 3) ? 256 : i + 1;
      wr(`OCC_ADDR_DIV5, 8'(e - 1));
      repeat (3) out_rise(r);
      chk(16'(r), 16'(e));
    end
    // Every source code, doubler off and on
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 2; j++) begin
        @(posedge clock);
        doubler_en <= (j != 0);
        wr(`OCC_ADDR_CTL6, {2'(i), 6'b011000});
        repeat (8) step();
        rd(`OCC_ADDR_STAT, 8'h07, {5'h00, 2'b11, i >= 2});
        r = 0;
        c = pin_p;
        repeat (840) begin
          step();
          if (pin_p && !c) r++;
          c = pin_p;
        end
        e = (i == 0) ? 105 : (i == 1) ? 70 : (i == 2) ? (j ? 140 : 210) : (j ? 60 : 84);
        chk(16'(r >= e - 1 && r <= e + 1), 16'h0001);
      end
    end
    // Formats and leg modes on the primary reference, two cycles behind it
    @(posedge clock);
    doubler_en <= 1'b0;
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 4; j++) begin
        wr(`OCC_ADDR_CTL6, {2'b10, 2'(i), 2'(j), 2'(3 - j)});
        repeat (4) step();
        repeat (8) begin
          step();
          c = w(cnt - 2, 2);
          chk(16'({p_oe, p_oe & pin_p}), 16'(leg(i, j, c, 1'b0)));
          chk(16'({n_oe, n_oe & pin_n}), 16'(leg(i, 3 - j, c, 1'b1)));
        end
      end
    end
    conclude();
  end
endmodule // tb
